// >>> src/bcc_pkg.sv
// Shared constants and types for the block check accumulator
package bcc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_CHAR = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_CHECK = 8'h14;
    localparam logic [7:0] ADDR_CLASS = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_POLY_LSB = 0;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_RX_BIT = 4;
    localparam int CTRL_PAR_EN_BIT = 5;
    localparam int CTRL_PAR_ODD_BIT = 6;
    localparam int CTRL_ESC_LSB = 8;
    localparam int CMD_CLEAR_BIT = 0;
    localparam int CMD_START_BIT = 1;
    localparam int CHAR_PAR_BIT = 8;
    localparam int CLASS_CLS_LSB = 8;
    localparam int CLASS_WE_BIT = 15;
    localparam int STAT_TRANSP_BIT = 4;
    localparam int STAT_ARMED_BIT = 5;
    localparam int STAT_ESC_BIT = 6;
    localparam int STAT_DONE_BIT = 7;
    localparam int FLAG_CRC = 0;
    localparam int FLAG_PAR = 1;
    localparam int FLAG_END = 2;
    localparam int FLAG_SEARCH = 3;
    localparam int NUM_FLAGS = 4;
    localparam int NUM_CODES = 128;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET = 16'h1000;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [1:0] POLY_CRC16 = 2'h0;
    localparam logic [1:0] POLY_CRC12 = 2'h1;
    localparam logic [1:0] POLY_LRC8 = 2'h2;
    localparam logic [15:0] GEN_CRC16 = 16'ha001;
    localparam logic [15:0] GEN_CRC12 = 16'h0f01;
    localparam logic [1:0] CHECK_CHARS_CRC = 2'h2;
    localparam logic [1:0] CHECK_CHARS_LRC = 2'h1;

    typedef enum logic [1:0] {
        cls_normal, cls_sync, cls_block_end, cls_second_search
    } char_class_t;

    typedef enum logic [1:0] {
        mode_normal, mode_transparent, mode_automatic, mode_single
    } accum_mode_t;

    typedef enum logic [1:0] {
        st_text, st_check, st_done
    } block_state_t;

endpackage : bcc_pkg

// >>> src/class_if.sv
// Carrier between the accumulator and its character class store
`timescale 1ns/1ps
interface class_if;
    import bcc_pkg::*;
    logic wr_en;
    logic [6:0] wr_idx;
    char_class_t wr_class;
    logic [6:0] lk_idx;
    char_class_t lk_class;
    logic [6:0] rd_idx;
    char_class_t rd_class;
    modport store (input wr_en, input wr_idx, input wr_class, input lk_idx, input rd_idx,
                   output lk_class, output rd_class);
    modport user (output wr_en, output wr_idx, output wr_class, output lk_idx,
                  output rd_idx, input lk_class, input rd_class);
endinterface : class_if

// >>> src/char_class_store.sv
// Per-code character class table, one flip-flop pair per code
`timescale 1ns/1ps
module char_class_store (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    class_if.store cif
);
    import bcc_pkg::*;

    char_class_t table_r [NUM_CODES];

    // ------------------------------------------------------------
    // Entries
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_CODES; g++) begin : g_entry
        always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
            if (!i_rst_b) begin
                table_r[g] <= cls_normal;
            end else if (i_ce && cif.wr_en && cif.wr_idx == 7'(g)) begin
                table_r[g] <= cif.wr_class;
            end
        end
    end

    assign cif.lk_class = table_r[cif.lk_idx];
    assign cif.rd_class = table_r[cif.rd_idx];

endmodule : char_class_store

// >>> src/bcc_accumulator.sv
// Block check accumulator with character classes and register slave
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps

// Overview of operation
// - Escape then second-search start enters transparent framing
// - Transparent: unescaped control characters count as data
// - Check character follows the block terminator
// - Sync-class characters excluded from check in normal mode
// - Transparent: escape of escape pair excluded
// - Polynomial selectable: CRC-16, CRC-12, LONGITUDINAL_CHECK-8
// - Four maskable conditions on one open-drain request
// - Every character mapped to one of four classes
// - Class store holds 128 character codes
// - Sync class kept out in normal mode
// - Terminator class raises terminator-detected condition
// - Second-search class detected only after escape
// - Normal mode accumulates all but sync class
// - Transparent mode drops first escape of pair
// - Automatic mode accumulates every character
// - Parity checked on every passing character
// - One character per clock, well above 500k/s
module bcc_accumulator (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp,
    input wire logic i_char_valid,
    input wire logic [7:0] i_char_data,
    input wire logic i_char_par,
    output logic o_char_ready,
    output logic [15:0] o_block_check_char,
    output logic o_irq_o,
    output logic o_irq_oe
);
    import bcc_pkg::*;

    // ------------------------------------------------------------
    // Check folding
    // ------------------------------------------------------------
    function automatic logic [15:0] fold(input logic [15:0] acc, input logic [7:0] c,
                                         input logic [1:0] poly);
        logic [15:0] a;
        logic [15:0] gen;
        logic fb;
        a = acc;
        gen = (poly == POLY_CRC12) ? GEN_CRC12 : GEN_CRC16;
        if (poly == POLY_LRC8) begin
            a = {8'h00, a[7:0] ^ c};
        end else begin
            for (int i = 0; i < 8; i++) begin
                fb = a[0] ^ c[i];
                a = a >> 1;
                if (fb) begin
                    a = a ^ gen;
                end
            end
        end
        return a;
    endfunction : fold

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] ctrl_r;
    logic [3:0] mask_r;
    logic [3:0] flags_r;
    logic [15:0] acc_r;
    logic [15:0] acc_nxt;
    logic esc_pend_r;
    logic in_transp_r;
    logic armed_r;
    logic [1:0] chk_cnt_r;
    logic [6:0] class_sel_r;
    block_state_t state_r;
    logic wr_pend_r;
    logic [7:0] addr_r;
    logic [31:0] hrdata_r;

    class_if cif ();

    char_class_store u_store (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .cif(cif)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic addr_phase;
    logic wr_ctrl;
    logic wr_cmd;
    logic wr_stat;
    logic wr_mask;
    logic wr_class;
    logic bus_char;

    assign addr_phase = i_ce && i_hsel && i_hready && i_htrans[1];
    assign wr_ctrl = i_ce && wr_pend_r && addr_r == ADDR_CTRL;
    assign wr_cmd = i_ce && wr_pend_r && addr_r == ADDR_CMD;
    assign bus_char = i_ce && wr_pend_r && addr_r == ADDR_CHAR;
    assign wr_stat = i_ce && wr_pend_r && addr_r == ADDR_STAT;
    assign wr_mask = i_ce && wr_pend_r && addr_r == ADDR_MASK;
    assign wr_class = i_ce && wr_pend_r && addr_r == ADDR_CLASS;

    // Frozen clock enable also holds the data phase
    assign o_hreadyout = i_ce;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_r;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else if (i_ce) begin
            wr_pend_r <= addr_phase && i_hwrite;
            addr_r <= i_haddr[7:0];
        end
    end

    // ------------------------------------------------------------
    // Character source
    // ------------------------------------------------------------
    // Bus write to the character register wins; the port waits a cycle
    logic char_go;
    logic [7:0] cdat;
    logic cpar;
    char_class_t cls;
    accum_mode_t mode;
    logic [1:0] poly;
    logic [7:0] esc_code;
    logic is_esc;
    logic par_bad;
    logic end_hit;
    logic search_hit;
    logic clear_cmd;
    logic check_last;

    assign o_char_ready = i_ce && !bus_char;
    assign char_go = bus_char || (i_char_valid && o_char_ready);
    assign cdat = bus_char ? i_hwdata[7:0] : i_char_data;
    assign cpar = bus_char ? i_hwdata[CHAR_PAR_BIT] : i_char_par;
    assign poly = ctrl_r[CTRL_POLY_LSB +: 2];
    assign mode = accum_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
    assign esc_code = ctrl_r[CTRL_ESC_LSB +: 8];
    assign is_esc = cdat == esc_code;
    assign clear_cmd = wr_cmd && i_hwdata[CMD_CLEAR_BIT];

    assign cif.lk_idx = cdat[6:0];
    assign cls = cif.lk_class;
    assign cif.wr_en = wr_class && i_hwdata[CLASS_WE_BIT];
    assign cif.wr_idx = i_hwdata[6:0];
    assign cif.wr_class = char_class_t'(i_hwdata[CLASS_CLS_LSB +: 2]);
    assign cif.rd_idx = class_sel_r;

    // Parity over data and parity bit
    assign par_bad = char_go && ctrl_r[CTRL_PAR_EN_BIT] &&
                     ((^{cdat, cpar}) != ctrl_r[CTRL_PAR_ODD_BIT]);

    // Terminator must be escaped inside transparent text
    assign end_hit = char_go && state_r == st_text && cls == cls_block_end &&
                     (!in_transp_r || esc_pend_r);
    assign search_hit = char_go && state_r == st_text && cls == cls_second_search &&
                        esc_pend_r;

    assign check_last = state_r == st_check &&
        chk_cnt_r == ((poly == POLY_LRC8) ? CHECK_CHARS_LRC : CHECK_CHARS_CRC) - 2'h1;

    // ------------------------------------------------------------
    // Accumulation decision
    // ------------------------------------------------------------
    // Whole character folds in one cycle: 80 chars per 500k/s slot
    always_comb begin
        acc_nxt = acc_r;
        if (char_go && state_r == st_check) begin
            acc_nxt = fold(acc_r, cdat, poly);
        end else if (char_go && state_r == st_text) begin
            unique case (mode)
                mode_normal: begin
                    if (cls != cls_sync) begin
                        acc_nxt = fold(acc_r, cdat, poly);
                    end
                end
                mode_transparent: begin
                    if (esc_pend_r && cls == cls_sync) begin
                        acc_nxt = fold(fold(acc_r, esc_code, poly), cdat, poly);
                    end else if (esc_pend_r || !is_esc) begin
                        acc_nxt = fold(acc_r, cdat, poly);
                    end
                end
                mode_automatic: begin
                    acc_nxt = fold(acc_r, cdat, poly);
                end
                mode_single: begin
                    if (armed_r) begin
                        acc_nxt = fold(acc_r, cdat, poly);
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Accumulator and block sequencing
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            acc_r <= 16'h0000;
        end else if (i_ce) begin
            if (clear_cmd) begin
                acc_r <= 16'h0000;
            end else begin
                acc_r <= acc_nxt;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= st_text;
            chk_cnt_r <= 2'h0;
        end else if (i_ce) begin
            if (clear_cmd) begin
                state_r <= st_text;
                chk_cnt_r <= 2'h0;
            end else if (end_hit) begin
                // Check characters follow the terminator directly
                state_r <= ctrl_r[CTRL_RX_BIT] ? st_check : st_done;
                chk_cnt_r <= 2'h0;
            end else if (char_go && state_r == st_check) begin
                chk_cnt_r <= chk_cnt_r + 2'h1;
                if (check_last) begin
                    state_r <= st_done;
                end
            end
        end
    end

    // Odd run of escapes marks the next character as escaped
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            esc_pend_r <= 1'b0;
        end else if (i_ce) begin
            if (clear_cmd) begin
                esc_pend_r <= 1'b0;
            end else if (char_go) begin
                esc_pend_r <= !esc_pend_r && is_esc;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            in_transp_r <= 1'b0;
        end else if (i_ce) begin
            if (clear_cmd || end_hit) begin
                in_transp_r <= 1'b0;
            end else if (search_hit) begin
                in_transp_r <= 1'b1;
            end
        end
    end

    // Start command arms one character; a new arm wins over consumption
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            armed_r <= 1'b0;
        end else if (i_ce) begin
            if (wr_cmd && i_hwdata[CMD_START_BIT]) begin
                armed_r <= 1'b1;
            end else if (char_go) begin
                armed_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Conditions and request output
    // ------------------------------------------------------------
    logic [3:0] flag_set;

    always_comb begin
        flag_set = 4'h0;
        flag_set[FLAG_CRC] = char_go && check_last && acc_nxt != 16'h0000;
        flag_set[FLAG_PAR] = par_bad;
        flag_set[FLAG_END] = end_hit;
        flag_set[FLAG_SEARCH] = search_hit;
    end

    // Write one to clear; a new event in the same cycle survives
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flags_r <= 4'h0;
        end else if (i_ce) begin
            flags_r <= (flags_r & ~(wr_stat ? i_hwdata[3:0] : 4'h0)) | flag_set;
        end
    end

    // Open drain: only ever pulls low
    assign o_irq_o = 1'b0;
    assign o_irq_oe = |(flags_r & mask_r);
    assign o_block_check_char = acc_r;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= i_hwdata[15:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mask_r <= MASK_RESET;
        end else if (wr_mask) begin
            mask_r <= i_hwdata[NUM_FLAGS-1:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            class_sel_r <= 7'h00;
        end else if (wr_class) begin
            class_sel_r <= i_hwdata[6:0];
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd_val;

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (i_haddr[7:0])
            ADDR_CTRL: rd_val = {16'h0000, ctrl_r};
            ADDR_STAT: begin
                rd_val[3:0] = flags_r;
                rd_val[STAT_TRANSP_BIT] = in_transp_r;
                rd_val[STAT_ARMED_BIT] = armed_r;
                rd_val[STAT_ESC_BIT] = esc_pend_r;
                rd_val[STAT_DONE_BIT] = state_r == st_done;
            end
            ADDR_MASK: rd_val = {28'h0000000, mask_r};
            ADDR_CHECK: rd_val = {16'h0000, acc_r};
            ADDR_CLASS: rd_val = {22'h000000, cif.rd_class, 1'b0, class_sel_r};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Sampled at the address phase, shown during the data phase
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hrdata_r <= 32'h0000_0000;
        end else if (addr_phase && !i_hwrite) begin
            hrdata_r <= rd_val;
        end
    end

endmodule : bcc_accumulator

// >>> testbench/bcc_accumulator_checker.sv
// Port checker for the block check accumulator
`timescale 1ns/1ps
module bcc_accumulator_checker
    import bcc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hresp,
    input wire logic i_char_valid,
    input wire logic [7:0] i_char_data,
    input wire logic o_char_ready,
    input wire logic [15:0] o_block_check_char,
    input wire logic o_irq_o,
    input wire logic o_irq_oe
);
    // ----------------------------------------
    // Bus shadow
    // ----------------------------------------
    logic wph_r;
    logic [7:0] wa_r;
    logic [3:0] ctrl_r;
    logic [3:0] mask_r;
    wire logic ap = i_hsel && i_hready && i_htrans[1] && i_ce;
    wire logic take = i_char_valid && o_char_ready;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wph_r <= 1'b0;
            wa_r <= 8'h00;
        end else if (i_ce) begin
            wph_r <= ap && i_hwrite;
            wa_r <= i_haddr[7:0];
        end
    end
    // Only poly and mode kept; enough for the fold check
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_r <= CTRL_RESET[3:0];
            mask_r <= MASK_RESET;
        end else if (i_ce && wph_r) begin
            if (wa_r == ADDR_CTRL) begin
                ctrl_r <= i_hwdata[3:0];
            end
            if (wa_r == ADDR_MASK) begin
                mask_r <= i_hwdata[3:0];
            end
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);
    property p_okay;
        !o_hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("bus response not okay");
    property p_ready;
        o_hreadyout == i_ce;
    endproperty
    a_ready: assert property (p_ready) else $error("hreadyout differs from enable");
    property p_irq_od;
        !o_irq_o;
    endproperty
    a_irq_od: assert property (p_irq_od) else $error("request pin driven high");
    property p_char_ready;
        o_char_ready == (i_ce && !(wph_r && wa_r == ADDR_CHAR));
    endproperty
    a_char_ready: assert property (p_char_ready) else $error("char ready wrong");
    property p_check_hold;
        !take && !wph_r |=> $stable(o_block_check_char);
    endproperty
    a_check_hold: assert property (p_check_hold) else $error("check moved without cause");
    property p_freeze;
        !i_ce |=> $stable(o_block_check_char) && $stable(o_irq_oe) && $stable(o_hrdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");
    property p_rdata;
        !(ap && !i_hwrite) |=> $stable(o_hrdata);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data changed early");
    property p_irq_mask;
        mask_r == 4'h0 && $past(mask_r) == 4'h0 |-> !o_irq_oe;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("request while masked");
    property p_lrc;
        take && !wph_r && ctrl_r == {mode_automatic, POLY_LRC8} |=>
            (o_block_check_char ^ $past(o_block_check_char)) == {8'h00, $past(i_char_data)};
    endproperty
    a_lrc: assert property (p_lrc) else $error("lrc fold wrong");
endmodule : bcc_accumulator_checker

bind bcc_accumulator bcc_accumulator_checker u_chk (.i_clk_sys, .i_rst_b, .i_ce, .i_hsel,
    .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hrdata, .o_hresp,
    .i_char_valid, .i_char_data, .o_char_ready, .o_block_check_char, .o_irq_o, .o_irq_oe);

// >>> testbench/char_feeder.sv
// Comms controller model offering characters to the accumulator
`timescale 1ns/1ps
module char_feeder (
    input wire logic i_clk_sys,
    input wire logic i_char_ready,
    output logic o_char_valid,
    output logic [7:0] o_char_data,
    output logic o_char_par
);
    int gap = 0;
    initial begin
        o_char_valid = 1'b0;
        o_char_data = 8'h00;
        o_char_par = 1'b0;
    end
    // ----------------------------------------
    // Character offer
    // ----------------------------------------
    task automatic send(input logic [7:0] d, input logic p);
        logic r;
        repeat (gap) @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        o_char_valid <= 1'b1;
        o_char_data <= d;
        o_char_par <= p;
        do begin
            @(negedge i_clk_sys);
            r = i_char_ready;
            @(posedge i_clk_sys);
        end while (!r);
        o_char_valid <= 1'b0;
        // Released lines invert so stale data never looks valid
        o_char_data <= ~d;
        o_char_par <= ~p;
    endtask : send
endmodule : char_feeder

// >>> testbench/tb_bcc_accumulator.sv
// Self-checking bench for the block check accumulator
`timescale 1ns/1ps
module tb_bcc_accumulator;
    import bcc_pkg::*;
    logic clk, rst_b, ce, hsel, hwrite, hreadyout, hresp, cv, cp, crdy, irq_o, irq_oe;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [7:0] cd;
    logic [15:0] chk_v, e, c;
    logic [7:0] msg [3] = '{8'h16, 8'h41, 8'h80};
    int n_mismatch, n_tests, cyc;
    bcc_accumulator DUT (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hrdata(hrdata), .o_hresp(hresp),
        .i_char_valid(cv), .i_char_data(cd), .i_char_par(cp), .o_char_ready(crdy),
        .o_block_check_char(chk_v), .o_irq_o(irq_o), .o_irq_oe(irq_oe)
    );
    char_feeder u_src (
        .i_clk_sys(clk), .i_char_ready(crdy), .o_char_valid(cv), .o_char_data(cd),
        .o_char_par(cp)
    );
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        logic r;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        for (int ph = 0; ph < 2; ph++) begin
            do begin
                @(negedge clk);
                r = hreadyout;
                q = hrdata;
                @(posedge clk);
            end while (!r);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, x);
    endtask : rd
    task automatic cc(input logic [15:0] x);
        rd(ADDR_CHECK, {16'h0, x});
        check({16'h0, chk_v}, {16'h0, x});
    endtask : cc
    // Clear command, then a status write drops flags so each case starts clean
    task automatic setup(input logic [15:0] v);
        wr(ADDR_CTRL, {16'h0, v});
        wr(ADDR_CMD, 32'h1);
        wr(ADDR_STAT, 32'hf);
        e = 16'h0;
    endtask : setup
    function automatic logic [15:0] fold(logic [15:0] a, logic [7:0] b, logic [1:0] p);
        if (p == POLY_LRC8) begin
            return a ^ {8'h00, b};
        end
        for (int i = 0; i < 8; i++) begin
            a = (a >> 1) ^ ((a[0] ^ b[i]) ? (p == POLY_CRC16 ? GEN_CRC16 : GEN_CRC12) : 16'h0);
        end
        return a;
    endfunction : fold
    task automatic tx(input logic [7:0] d, input logic inc);
        u_src.send(d, ^d);
        if (inc) begin
            e = fold(e, d, POLY_CRC16);
        end
    endtask : tx
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
        ce = 1'b1;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        check({31'h0, hreadyout}, 32'h0);
        ce <= 1'b1;
        rd(ADDR_CTRL, {16'h0, CTRL_RESET});
        rd(ADDR_MASK, 32'h0);
        cc(16'h0);
        rd(8'h40, 32'h0);
        wr(ADDR_CLASS, 32'h8116);
        wr(ADDR_CLASS, 32'h817f);
        rd(ADDR_CLASS, 32'h017f);
        wr(ADDR_CLASS, 32'h8203);
        wr(ADDR_CLASS, 32'h8302);
        for (int p = 0; p < 3; p++) begin
            setup({14'h0402, p[1:0]});
            for (int i = 0; i < 3; i++) begin
                u_src.send(msg[i], ^msg[i]);
                e = fold(e, msg[i], p[1:0]);
            end
            cc(e);
        end
        setup(16'h1000);
        u_src.gap = 2;
        tx(8'h16, 1'b0);
        tx(8'h16, 1'b0);
        u_src.gap = 0;
        tx(8'h41, 1'b1);
        tx(8'h42, 1'b1);
        cc(e);
        setup(16'h1004);
        tx(8'h10, 1'b0);
        tx(8'h41, 1'b1);
        cc(e);
        tx(8'h10, 1'b0);
        tx(8'h10, 1'b1);
        tx(8'h42, 1'b1);
        cc(e);
        setup(16'h1000);
        tx(8'h10, 1'b1);
        tx(8'h02, 1'b1);
        rd(ADDR_STAT, 32'h18);
        setup(16'h1000);
        wr(ADDR_MASK, 32'h4);
        tx(8'h41, 1'b1);
        check({31'h0, irq_oe}, 32'h0);
        tx(8'h03, 1'b1);
        rd(ADDR_STAT, 32'h84);
        check({31'h0, irq_oe}, 32'h1);
        wr(ADDR_MASK, 32'h0);
        @(negedge clk);
        check({31'h0, irq_oe}, 32'h0);
        wr(ADDR_STAT, 32'h4);
        rd(ADDR_STAT, 32'h80);
        tx(8'h44, 1'b0);
        cc(e);
        setup(16'h1020);
        u_src.send(8'h41, 1'b0);
        rd(ADDR_STAT, 32'h0);
        u_src.send(8'h41, 1'b1);
        rd(ADDR_STAT, 32'h2);
        setup(16'h1060);
        u_src.send(8'h41, 1'b1);
        rd(ADDR_STAT, 32'h0);
        for (int k = 0; k < 2; k++) begin
            setup(16'h1010);
            tx(8'h41, 1'b1);
            tx(8'h03, 1'b1);
            c = e;
            tx(c[7:0], 1'b0);
            tx(c[15:8] ^ k[7:0], 1'b0);
            rd(ADDR_STAT, 32'h84 | k);
        end
        setup(16'h100c);
        tx(8'h41, 1'b0);
        wr(ADDR_CHAR, 32'h41);
        cc(e);
        wr(ADDR_CMD, 32'h2);
        tx(8'h42, 1'b1);
        cc(e);
        results();
    end
endmodule : tb_bcc_accumulator
